//--- lcp_pkg.sv
package lcp_pkg;

  // Register byte offsets.
  localparam logic [7:0] LINK_CAP_TWO_OFS = 8'h6C;
  localparam logic [7:0] LINK_CTL_TWO_OFS = 8'h70;
  localparam logic [7:0] LINK_STS_TWO_OFS = 8'h72;
  localparam logic [7:0] SLOT_CAP_TWO_OFS = 8'h74;
  localparam logic [7:0] SLOT_CTL_TWO_OFS = 8'h78;
  localparam logic [7:0] SLOT_STS_TWO_OFS = 8'h7A;
  localparam logic [7:0] PM_CAP_HDR_OFS = 8'hC0;

  // Link control two field positions.
  localparam int TGT_SPD_LSB = 0;
  localparam int TGT_SPD_MSB = 3;
  localparam int COMPL_ENTRY_BIT = 4;
  localparam int AUTO_SPD_DIS_BIT = 5;

  // Power management header field positions.
  localparam int CAP_ID_LSB = 0;
  localparam int CAP_ID_MSB = 7;
  localparam int NXT_LSB = 8;
  localparam int NXT_MSB = 15;
  localparam int PM_VERSION_LSB = 16;
  localparam int PM_VERSION_MSB = 18;
  localparam int WAKE_CLK_BIT = 19;
  localparam int DEV_INIT_BIT = 21;
  localparam int AUX_LSB = 22;
  localparam int AUX_MSB = 24;
  localparam int LIGHT_SLEEP_BIT = 25;
  localparam int DEEPER_SLEEP_BIT = 26;
  localparam int WAKE_SUP_LSB = 27;
  localparam int WAKE_SUP_MSB = 31;

  // Speed codes.
  localparam logic [3:0] SPEED_2G5 = 4'h1;
  localparam logic [3:0] SPEED_5G = 4'h2;
  localparam logic [3:0] SPEED_MAX_SUPPORTED = SPEED_2G5;

  // Reset and fixed values.
  localparam logic [3:0] TGT_SPD_RST = 4'h0;
  localparam logic COMPL_ENTRY_RST = 1'b0;
  localparam logic AUTO_SPD_DIS_RST = 1'b0;
  localparam logic [7:0] CAP_ID_VAL = 8'h01;
  localparam logic [7:0] NXT_UP_RST = 8'h00;
  localparam logic [7:0] NXT_DOWN_RST = 8'hD0;
  localparam logic [2:0] PM_VERSION_VAL = 3'h3;
  localparam logic DEV_INIT_RST = 1'b0;
  localparam logic [4:0] WAKE_SUP_RST = 5'h19;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Power states seen by the wake forwarding path.
  typedef enum logic [2:0] {
    LCP_PS_D0 = 3'b000,
    LCP_PS_D1 = 3'b001,
    LCP_PS_D2 = 3'b010,
    LCP_PS_D3HOT = 3'b011,
    LCP_PS_D3COLD = 3'b100
  } lcp_pstate_e;

  // Writable part of link control two.
  typedef struct packed {
    logic autonomous_speed_disable;
    logic compliance_entry_bit;
    logic [3:0] target_speed_field;
  } lcp_link_ctl_s;

  // Writable part of the power management header.
  typedef struct packed {
    logic [4:0] wake_sup;
    logic device_specific_init_flag;
    logic [7:0] nxt_ptr;
  } lcp_pm_hdr_s;

endpackage

//--- lcp_rst_sync.sv
`timescale 1ns/1ps
// Asserts reset at once and releases it after two clock edges.
module lcp_rst_sync (
  input wire logic clk,
  input wire logic arst_n,
  output logic srst_n
);

  logic stage_reg;

  // Two-flop release chain; only the second flop leaves the module.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_reg <= 1'b0;
      srst_n <= 1'b0;
    end else begin
      stage_reg <= 1'b1;
      srst_n <= stage_reg;
    end
  end

endmodule

//--- lcp_link_pm_regs.sv
`timescale 1ns/1ps
module lcp_link_pm_regs (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic port_is_downstream,
  input wire logic legacy_mode,
  input wire logic cfg_unlock,
  input wire logic hot_reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic speed_chg_req,
  input wire logic speed_chg_lower,
  input wire logic link_unreliable,
  output logic speed_chg_grant,
  output logic [3:0] train_speed_cap,
  output logic [3:0] compliance_speed,
  output logic compliance_enter,
  output logic autonomous_speed_disable,
  input wire logic wake_msg_in,
  input wire logic [2:0] power_state,
  output logic wake_msg_fwd
);

  logic srst_n;
  lcp_pkg::lcp_link_ctl_s link_ctl_reg;
  lcp_pkg::lcp_link_ctl_s link_ctl_next;
  lcp_pkg::lcp_pm_hdr_s pm_hdr_reg;
  lcp_pkg::lcp_pm_hdr_s pm_hdr_next;
  lcp_pkg::lcp_link_ctl_s link_ctl_eff;
  logic strap_done_reg;
  logic [31:0] rdata_next;
  logic [31:0] link_ctl_word;
  logic [31:0] pm_hdr_word;
  logic wr_link_ctl;
  logic wr_pm_hdr;
  logic grant_next;
  lcp_pkg::lcp_pstate_e pstate;

  lcp_rst_sync u_rst_sync (
    .clk(ref_clk),
    .arst_n(rst_n),
    .srst_n(srst_n)
  );

  assign pstate = lcp_pkg::lcp_pstate_e'(power_state);
  assign wr_link_ctl = reg_wr && (reg_addr == lcp_pkg::LINK_CTL_TWO_OFS);
  assign wr_pm_hdr = reg_wr && (reg_addr == lcp_pkg::PM_CAP_HDR_OFS);

  // Fields seen by the link logic; legacy mode forces them all to zero.
  always_comb begin
    link_ctl_eff = link_ctl_reg;
    if (legacy_mode) begin
      link_ctl_eff = '0;
    end
  end

  // Next value of link control two; legacy mode drops the write.
  always_comb begin
    link_ctl_next = link_ctl_reg;
    if (wr_link_ctl && !legacy_mode) begin
      link_ctl_next.target_speed_field =
        reg_wdata[lcp_pkg::TGT_SPD_MSB:lcp_pkg::TGT_SPD_LSB];
      link_ctl_next.compliance_entry_bit =
        reg_wdata[lcp_pkg::COMPL_ENTRY_BIT];
      link_ctl_next.autonomous_speed_disable =
        reg_wdata[lcp_pkg::AUTO_SPD_DIS_BIT];
    end
    if (hot_reset) begin
      // A hot reset clears the non-sticky fields; compliance entry stays.
      link_ctl_next.target_speed_field = lcp_pkg::TGT_SPD_RST;
      link_ctl_next.autonomous_speed_disable = lcp_pkg::AUTO_SPD_DIS_RST;
      link_ctl_next.compliance_entry_bit =
        link_ctl_reg.compliance_entry_bit;
    end
  end

  // Link control two storage.
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      link_ctl_reg.target_speed_field <= lcp_pkg::TGT_SPD_RST;
      link_ctl_reg.compliance_entry_bit <= lcp_pkg::COMPL_ENTRY_RST;
      link_ctl_reg.autonomous_speed_disable <= lcp_pkg::AUTO_SPD_DIS_RST;
    end else begin
      link_ctl_reg <= link_ctl_next;
    end
  end

  // Next value of the writable header fields; they open only when unlocked.
  always_comb begin
    pm_hdr_next = pm_hdr_reg;
    if (!strap_done_reg) begin
      // The port role is caught once, just after reset release.
      pm_hdr_next.nxt_ptr = port_is_downstream ? lcp_pkg::NXT_DOWN_RST
                                               : lcp_pkg::NXT_UP_RST;
    end else if (wr_pm_hdr && cfg_unlock) begin
      pm_hdr_next.nxt_ptr = reg_wdata[lcp_pkg::NXT_MSB:lcp_pkg::NXT_LSB];
      pm_hdr_next.device_specific_init_flag =
        reg_wdata[lcp_pkg::DEV_INIT_BIT];
      pm_hdr_next.wake_sup =
        reg_wdata[lcp_pkg::WAKE_SUP_MSB:lcp_pkg::WAKE_SUP_LSB];
    end
  end

  // Power management header storage.
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      pm_hdr_reg.nxt_ptr <= lcp_pkg::NXT_UP_RST;
      pm_hdr_reg.device_specific_init_flag <= lcp_pkg::DEV_INIT_RST;
      pm_hdr_reg.wake_sup <= lcp_pkg::WAKE_SUP_RST;
    end else begin
      pm_hdr_reg <= pm_hdr_next;
    end
  end

  // Marks that the port role has been caught.
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      strap_done_reg <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
    end
  end

  // Word images of the two live registers; unlisted bits stay zero.
  always_comb begin
    link_ctl_word = lcp_pkg::ZERO_WORD;
    link_ctl_word[lcp_pkg::TGT_SPD_MSB:lcp_pkg::TGT_SPD_LSB] =
      link_ctl_eff.target_speed_field;
    link_ctl_word[lcp_pkg::COMPL_ENTRY_BIT] =
      link_ctl_eff.compliance_entry_bit;
    link_ctl_word[lcp_pkg::AUTO_SPD_DIS_BIT] =
      link_ctl_eff.autonomous_speed_disable;
  end

  always_comb begin
    pm_hdr_word = lcp_pkg::ZERO_WORD;
    pm_hdr_word[lcp_pkg::CAP_ID_MSB:lcp_pkg::CAP_ID_LSB] =
      lcp_pkg::CAP_ID_VAL;
    pm_hdr_word[lcp_pkg::NXT_MSB:lcp_pkg::NXT_LSB] = pm_hdr_reg.nxt_ptr;
    pm_hdr_word[lcp_pkg::PM_VERSION_MSB:lcp_pkg::PM_VERSION_LSB] =
      lcp_pkg::PM_VERSION_VAL;
    pm_hdr_word[lcp_pkg::WAKE_CLK_BIT] = 1'b0;
    pm_hdr_word[lcp_pkg::DEV_INIT_BIT] =
      pm_hdr_reg.device_specific_init_flag;
    pm_hdr_word[lcp_pkg::AUX_MSB:lcp_pkg::AUX_LSB] = 3'h0;
    pm_hdr_word[lcp_pkg::LIGHT_SLEEP_BIT] = 1'b0;
    pm_hdr_word[lcp_pkg::DEEPER_SLEEP_BIT] = 1'b0;
    pm_hdr_word[lcp_pkg::WAKE_SUP_MSB:lcp_pkg::WAKE_SUP_LSB] =
      pm_hdr_reg.wake_sup;
  end

  // Read decode; the zero registers and unmapped addresses return zero.
  always_comb begin
    rdata_next = lcp_pkg::ZERO_WORD;
    if (reg_rd) begin
      case (reg_addr)
        lcp_pkg::LINK_CTL_TWO_OFS: rdata_next = link_ctl_word;
        lcp_pkg::PM_CAP_HDR_OFS: rdata_next = pm_hdr_word;
        lcp_pkg::LINK_CAP_TWO_OFS,
        lcp_pkg::LINK_STS_TWO_OFS,
        lcp_pkg::SLOT_CAP_TWO_OFS,
        lcp_pkg::SLOT_CTL_TWO_OFS,
        lcp_pkg::SLOT_STS_TWO_OFS: rdata_next = lcp_pkg::ZERO_WORD;
        default: rdata_next = lcp_pkg::ZERO_WORD;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      reg_rdata <= lcp_pkg::ZERO_WORD;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  // Training cap: downstream ports advertise the target, clipped to 2.5 Gbps.
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      train_speed_cap <= lcp_pkg::SPEED_MAX_SUPPORTED;
    end else if (port_is_downstream &&
                 link_ctl_eff.target_speed_field != 4'h0) begin
      if (link_ctl_eff.target_speed_field >
          lcp_pkg::SPEED_MAX_SUPPORTED) begin
        train_speed_cap <= lcp_pkg::SPEED_MAX_SUPPORTED;
      end else begin
        train_speed_cap <= link_ctl_eff.target_speed_field;
      end
    end else begin
      train_speed_cap <= lcp_pkg::SPEED_MAX_SUPPORTED;
    end
  end

  // Compliance speed follows the target field on either port role.
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      compliance_speed <= 4'h0;
    end else begin
      compliance_speed <= link_ctl_eff.target_speed_field;
    end
  end

  // A hot reset with compliance entry set sends the link to compliance.
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      compliance_enter <= 1'b0;
    end else begin
      compliance_enter <= hot_reset &&
                          link_ctl_eff.compliance_entry_bit;
    end
  end

  // Speed change arbitration under the autonomous disable bit.
  always_comb begin
    grant_next = 1'b0;
    if (speed_chg_req) begin
      if (!link_ctl_eff.autonomous_speed_disable) begin
        grant_next = 1'b1;
      end else begin
        grant_next = speed_chg_lower && link_unreliable;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      speed_chg_grant <= 1'b0;
      autonomous_speed_disable <= 1'b0;
    end else begin
      speed_chg_grant <= grant_next;
      autonomous_speed_disable <= link_ctl_eff.autonomous_speed_disable;
    end
  end

  // Wake messages pass on except in the unpowered deep-sleep state.
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      wake_msg_fwd <= 1'b0;
    end else begin
      wake_msg_fwd <= wake_msg_in &&
                      (pstate != lcp_pkg::LCP_PS_D3COLD);
    end
  end

endmodule

//--- lcp_link_pm_regs_properties.sv
`timescale 1ns/1ps
// Watches the register port and the link side of the register slice.
module lcp_regs_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic legacy_mode,
  input wire logic hot_reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic speed_chg_req,
  input wire logic speed_chg_lower,
  input wire logic link_unreliable,
  input wire logic speed_chg_grant,
  input wire logic [3:0] train_speed_cap,
  input wire logic [3:0] compliance_speed,
  input wire logic compliance_enter,
  input wire logic autonomous_speed_disable,
  input wire logic wake_msg_in,
  input wire logic [2:0] power_state,
  input wire logic wake_msg_fwd
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wake_fwd_a:
    assert property (wake_msg_in |=>
      wake_msg_fwd == ($past(power_state) != 3'h4))
    else $error("wake forward mismatch");
  speed_lock_a:
    assert property (speed_chg_req && autonomous_speed_disable &&
      !(speed_chg_lower && link_unreliable) |=> !speed_chg_grant)
    else $error("speed change granted while disabled");
  grant_cause_a:
    assert property (speed_chg_grant |-> $past(speed_chg_req))
    else $error("grant without request");
  cap_fixed_a:
    assert property (train_speed_cap == 4'h1)
    else $error("training speed cap above supported");
  legacy_mask_a:
    assert property (legacy_mode |=>
      compliance_speed == 4'h0 && !autonomous_speed_disable)
    else $error("legacy mode outputs not zero");
  comp_enter_a:
    assert property (compliance_enter |-> $past(hot_reset))
    else $error("compliance entry without hot reset");
  rd_idle_a:
    assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  ro_zero_a:
    assert property (reg_rd && reg_addr inside {8'h6C, 8'h72, 8'h74,
      8'h78, 8'h7A} |=> reg_rdata == 32'h0)
    else $error("reserved register not zero");
  pm_fixed_a:
    assert property (reg_rd && reg_addr == 8'hC0 |=> reg_rdata[7:0] == 8'h01
      && reg_rdata[20:16] == 5'h03 && reg_rdata[26:22] == 5'h00)
    else $error("power header fixed fields wrong");
  legacy_rd_a:
    assert property (reg_rd && reg_addr == 8'h70 |=> reg_rdata[31:6] == 26'h0
      && !($past(legacy_mode) && reg_rdata != 32'h0))
    else $error("link control read wrong");
endmodule

bind lcp_link_pm_regs lcp_regs_checker chk_u (.*);

//--- lcp_far_end.sv
`timescale 1ns/1ps
// Far end of the link: issues hot reset, speed changes and wake messages.
module lcp_far_end (
  input wire logic ref_clk,
  output logic hot_reset,
  output logic speed_chg_req,
  output logic speed_chg_lower,
  output logic link_unreliable,
  output logic wake_msg_in
);
  // The link starts idle with no request pending.
  initial begin
    {hot_reset, speed_chg_req, speed_chg_lower} = 3'h0;
    {link_unreliable, wake_msg_in} = 2'h0;
  end
  // One-cycle speed request with its qualifiers held beside it.
  task automatic speed(input logic low, input logic unrel);
    @(posedge ref_clk);
    speed_chg_req <= 1'b1;
    speed_chg_lower <= low;
    link_unreliable <= unrel;
    @(posedge ref_clk);
    {speed_chg_req, speed_chg_lower, link_unreliable} <= 3'h0;
  endtask
  // One-cycle hot reset; it completes the entry only if the register slice's compliance entry bit is set.
  task automatic hot();
    @(posedge ref_clk);
    hot_reset <= 1'b1;
    @(posedge ref_clk);
    hot_reset <= 1'b0;
  endtask
  // A single wake message travelling upstream.
  task automatic wake();
    @(posedge ref_clk);
    wake_msg_in <= 1'b1;
    @(posedge ref_clk);
    wake_msg_in <= 1'b0;
  endtask
endmodule

//--- lcp_link_pm_regs_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the link control two and power header slice.
module lcp_link_pm_regs_bench;
  logic ref_clk, rst_n, port_is_downstream, legacy_mode, cfg_unlock;
  logic hot_reset, speed_chg_req, speed_chg_lower, link_unreliable;
  logic wake_msg_in, reg_wr, reg_rd, speed_chg_grant, compliance_enter;
  logic autonomous_speed_disable, wake_msg_fwd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [3:0] train_speed_cap, compliance_speed;
  logic [2:0] power_state;
  int bad_count = 0;
  int tests_run = 0;
  lcp_link_pm_regs dut_u (.*);
  lcp_far_end far_u (.*);
  // Free-running 200 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic do_reset(input logic down);
    @(posedge ref_clk);
    {rst_n, port_is_downstream} <= {1'b0, down};
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic t_map();
    logic [7:0] a [6] = '{8'h6C, 8'h72, 8'h74, 8'h78, 8'h7A, 8'h80};
    rd(8'h70);
    chk("ctl_reset", 32'h0, d);
    rd(8'hC0);
    chk("pm_down", 32'hC803D001, d);
    foreach (a[i]) begin
      wr(a[i], 32'hFFFFFFFF);
      rd(a[i]);
      chk("ro_reg", 32'h0, d);
    end
  endtask
  task automatic t_ctl();
    wr(8'h70, 32'hFFFFFFF1);
    rd(8'h70);
    chk("ctl_rd", 32'h31, d);
    chk("cmp_spd", 32'h1, {28'h0, compliance_speed});
    chk("cap", 32'h1, {28'h0, train_speed_cap});
    chk("asd", 32'h1, {31'h0, autonomous_speed_disable});
  endtask
  task automatic t_speed();
    far_u.speed(1'b0, 1'b0);
    #1 chk("grant_hold", {31'h0, speed_chg_grant}, 32'h0);
    far_u.speed(1'b1, 1'b0);
    #1 chk("grant_low", {31'h0, speed_chg_grant}, 32'h0);
    far_u.speed(1'b1, 1'b1);
    #1 chk("grant_fix", {31'h0, speed_chg_grant}, 32'h1);
    wr(8'h70, 32'h11);
    rd(8'h70);
    far_u.speed(1'b0, 1'b0);
    #1 chk("grant_free", {31'h0, speed_chg_grant}, 32'h1);
  endtask
  task automatic t_comp();
    far_u.hot();
    #1 chk("comp_on", {31'h0, compliance_enter}, 32'h1);
    rd(8'h70);
    chk("sticky", 32'h10, d);
    wr(8'h70, 32'h0);
    far_u.hot();
    #1 chk("comp_off", {31'h0, compliance_enter}, 32'h0);
  endtask
  task automatic t_legacy();
    wr(8'h70, 32'h21);
    @(posedge ref_clk) legacy_mode <= 1'b1;
    rd(8'h70);
    chk("leg_rd", 32'h0, d);
    wr(8'h70, 32'h11);
    #1 chk("leg_out", {27'h0, autonomous_speed_disable, compliance_speed},
      32'h0);
    @(posedge ref_clk) legacy_mode <= 1'b0;
    rd(8'h70);
    chk("leg_kept", 32'h21, d);
  endtask
  task automatic t_pm();
    wr(8'hC0, 32'h0);
    rd(8'hC0);
    chk("pm_lock", 32'hC803D001, d);
    @(posedge ref_clk) cfg_unlock <= 1'b1;
    wr(8'hC0, 32'hFFFFFFFF);
    rd(8'hC0);
    chk("pm_open", 32'hF823FF01, d);
    @(posedge ref_clk) cfg_unlock <= 1'b0;
  endtask
  task automatic t_wake();
    for (int s = 0; s < 5; s++) begin
      @(posedge ref_clk) power_state <= 3'(s);
      far_u.wake();
      #1 chk("wake", {31'h0, wake_msg_fwd}, 32'(s != 4));
    end
  endtask
  // Main sequence, then a second reset as an upstream port.
  initial begin
    {rst_n, port_is_downstream, legacy_mode, cfg_unlock} = 4'h4;
    {reg_addr, reg_wdata, reg_wr, reg_rd, power_state} = '0;
    do_reset(1'b1);
    t_map();
    t_ctl();
    t_speed();
    t_comp();
    t_legacy();
    t_pm();
    t_wake();
    do_reset(1'b0);
    rd(8'hC0);
    chk("pm_up", 32'hC8030001, d);
    stop_test();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end
endmodule
